// File: design/itpg_top.sv
// Chosen here: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
// internal oscillator tuning and multiplier gate, wishbone slave
module itpg_top #(
   parameter int unsigned SLOW_SETTLE = itpg_pkg::SLOW_SETTLE_CYC,
   parameter int unsigned FAST_SETTLE = itpg_pkg::FAST_SETTLE_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [3:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   input wire logic [3:0] i_primary_osc_config,
   input wire logic i_secondary_osc_en,
   output logic [4:0] o_fast_trim_code,
   output logic [4:0] o_slow_trim_code,
   output logic o_multiplier_on,
   output logic o_fast_osc_en,
   output logic o_slow_rc_en,
   output logic o_lf_from_fast_osc,
   output logic [2:0] o_internal_freq_select,
   output logic [1:0] o_clk_source,
   output logic o_secondary_keep_running,
   output logic o_pm_modes_avail,
   output logic [15:0] o_sys_freq_khz
);

   ////////////////////////////////////////////////////////////////////////
   // step intervals, never below one cycle
   localparam int unsigned SLOW_STEP =
      (SLOW_SETTLE / itpg_pkg::TRIM_SPAN < 1) ? 1 :
      SLOW_SETTLE / itpg_pkg::TRIM_SPAN;
   localparam int unsigned FAST_STEP =
      (FAST_SETTLE / itpg_pkg::TRIM_SPAN < 1) ? 1 :
      FAST_SETTLE / itpg_pkg::TRIM_SPAN;

   ////////////////////////////////////////////////////////////////////////
   // functions

   // internal block used as primary oscillator
   function automatic logic is_int_mode(input logic [3:0] cfg);
      is_int_mode = (cfg == itpg_pkg::CFG_INT_A) ||
                    (cfg == itpg_pkg::CFG_INT_B);
   endfunction

   // offset binary code: equal steps from minimum to maximum
   function automatic logic [4:0] to_code(input logic signed [4:0] t);
      to_code = {~t[4], t[3:0]};
   endfunction

   // clock source class from the select field
   function automatic itpg_pkg::itpg_src_type src_of(
      input logic [1:0] scs
   );
      if (scs[1]) begin
         src_of = itpg_pkg::SRC_INTERNAL;
      end else if (scs[0]) begin
         src_of = itpg_pkg::SRC_SECONDARY;
      end else begin
         src_of = itpg_pkg::SRC_PRIMARY;
      end
   endfunction

   // internal block output in kHz
   function automatic logic [15:0] ifs_khz(input logic [2:0] ifs);
      unique case (ifs)
         3'h7: ifs_khz = 16'h1F40;
         3'h6: ifs_khz = 16'h0FA0;
         3'h5: ifs_khz = 16'h07D0;
         3'h4: ifs_khz = 16'h03E8;
         3'h3: ifs_khz = 16'h01F4;
         3'h2: ifs_khz = 16'h00FA;
         3'h1: ifs_khz = 16'h007D;
         3'h0: ifs_khz = 16'h001F;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // declarations
   logic [3:0] cfg_meta_r;
   logic [3:0] cfg_r;
   logic sec_meta_r;
   logic sec_r;
   logic ack_r;
   logic [31:0] rd_dat_r;
   logic lf_src_r;
   logic mul_en_r;
   logic signed [4:0] trim_r;
   logic [2:0] ifs_r;
   logic [1:0] scs_r;
   logic wb_req;
   logic wr_byte0;
   logic wr_tun;
   logic wr_osc;
   logic mode_ok;
   logic freq_ok;
   logic mul_on;
   logic int_feeds;
   logic fast_en;
   itpg_pkg::itpg_src_type src;
   logic [15:0] base_khz;
   logic [15:0] freq_nxt;
   logic [7:0] tun_rd;
   logic [7:0] osc_rd;
   logic [15:0] stat_rd;
   logic [31:0] rd_nxt;

   itpg_trim_if fast_trim ();
   itpg_trim_if slow_trim ();

   ////////////////////////////////////////////////////////////////////////
   // primary configuration straps, two stages before any use
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         cfg_meta_r <= 4'h0;
         cfg_r <= 4'h0;
      end else begin
         cfg_meta_r <= i_primary_osc_config;
         cfg_r <= cfg_meta_r;
      end
   end

   // secondary oscillator enable, two stages before any use
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         sec_meta_r <= 1'b0;
         sec_r <= 1'b0;
      end else begin
         sec_meta_r <= i_secondary_osc_en;
         sec_r <= sec_meta_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bus decode
   assign wb_req = i_wb_cyc & i_wb_stb & ~ack_r;
   assign wr_byte0 = wb_req & i_wb_we & i_wb_sel[0];
   assign wr_tun = wr_byte0 & (i_wb_adr == itpg_pkg::ADR_TUNING);
   assign wr_osc = wr_byte0 & (i_wb_adr == itpg_pkg::ADR_OSC_CTRL);

   // acknowledge one cycle after the request, drop the next cycle
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= wb_req;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // tuning register: low frequency source select
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         lf_src_r <= 1'b0;
      end else if (wr_tun) begin
         lf_src_r <= i_wb_dat[itpg_pkg::TUN_LF_SRC_BIT];
      end
   end

   // tuning register: signed trim target
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         trim_r <= itpg_pkg::TRIM_RST;
      end else if (wr_tun) begin
         trim_r <= i_wb_dat[4:0];
      end
   end

   // multiplier enable, held clear outside the internal modes
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         mul_en_r <= 1'b0;
      end else if (!mode_ok) begin
         mul_en_r <= 1'b0;
      end else if (wr_tun) begin
         mul_en_r <= i_wb_dat[itpg_pkg::TUN_MUL_EN_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // oscillator control: frequency select, 1 MHz after every reset
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ifs_r <= itpg_pkg::IFS_RST;
      end else if (wr_osc) begin
         ifs_r <= i_wb_dat[itpg_pkg::OSC_IFS_LSB +: 3];
      end
   end

   // oscillator control: system clock select, primary after reset
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         scs_r <= itpg_pkg::SCS_RST;
      end else if (wr_osc) begin
         scs_r <= i_wb_dat[itpg_pkg::OSC_SCS_LSB +: 2];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // multiplier gate
   assign mode_ok = is_int_mode(cfg_r);
   assign freq_ok = (ifs_r == itpg_pkg::IFS_8M) ||
                    (ifs_r == itpg_pkg::IFS_4M);
   assign mul_on = mul_en_r & mode_ok & freq_ok;

   ////////////////////////////////////////////////////////////////////////
   // source and frequency
   assign src = src_of(scs_r);
   assign int_feeds = (src == itpg_pkg::SRC_INTERNAL) ||
                      (src == itpg_pkg::SRC_PRIMARY && mode_ok);
   assign fast_en = int_feeds & ((ifs_r != 3'h0) | lf_src_r);
   assign base_khz = ifs_khz(ifs_r);

   // resulting device clock, zero where an external source is unknown
   always_comb begin
      freq_nxt = 16'h0000;
      if (src == itpg_pkg::SRC_SECONDARY) begin
         freq_nxt = itpg_pkg::SEC_KHZ;
      end else if (int_feeds && mul_on) begin
         freq_nxt = base_khz << itpg_pkg::MUL_SHIFT;
      end else if (int_feeds) begin
         freq_nxt = base_khz;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // trim shifts, same target for both oscillators
   assign fast_trim.target = trim_r;
   assign slow_trim.target = trim_r;

   itpg_trim_slew #(
      .STEP_CYC(FAST_STEP)
   ) u_fast_slew (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .trim(fast_trim)
   );

   itpg_trim_slew #(
      .STEP_CYC(SLOW_STEP)
   ) u_slow_slew (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .trim(slow_trim)
   );

   ////////////////////////////////////////////////////////////////////////
   // read data; shift progress is deliberately not visible
   assign tun_rd = {lf_src_r, mul_en_r, 1'b0, trim_r};
   assign osc_rd = {1'b0, ifs_r, 2'b00, scs_r};
   assign stat_rd = {7'h00, fast_en, cfg_r, mode_ok, src, mul_on};

   always_comb begin
      rd_nxt = 32'h0000_0000;
      unique case (i_wb_adr)
         itpg_pkg::ADR_TUNING: rd_nxt = {24'h00_0000, tun_rd};
         itpg_pkg::ADR_OSC_CTRL: rd_nxt = {24'h00_0000, osc_rd};
         itpg_pkg::ADR_STATUS: rd_nxt = {16'h0000, stat_rd};
         default: rd_nxt = 32'h0000_0000;
      endcase
   end

   // read data captured with the acknowledge
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         rd_dat_r <= 32'h0000_0000;
      end else if (wb_req && !i_wb_we) begin
         rd_dat_r <= rd_nxt;
      end
   end

   assign o_wb_dat = rd_dat_r;
   assign o_wb_ack = ack_r;

   ////////////////////////////////////////////////////////////////////////
   // trim codes toward the two oscillators
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_fast_trim_code <= to_code(itpg_pkg::TRIM_RST);
         o_slow_trim_code <= to_code(itpg_pkg::TRIM_RST);
      end else begin
         o_fast_trim_code <= to_code(fast_trim.current);
         o_slow_trim_code <= to_code(slow_trim.current);
      end
   end

   // effective multiplier, only while the internal block feeds the clock
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_multiplier_on <= 1'b0;
      end else begin
         o_multiplier_on <= mul_on & int_feeds;
      end
   end

   // oscillator enables; the slow rc never stops
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_fast_osc_en <= 1'b0;
         o_slow_rc_en <= 1'b1;
      end else begin
         o_fast_osc_en <= fast_en;
         o_slow_rc_en <= 1'b1;
      end
   end

   // low frequency source of the 31 kHz option
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_lf_from_fast_osc <= 1'b0;
      end else begin
         o_lf_from_fast_osc <= lf_src_r;
      end
   end

   // frequency select and clock source class
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_internal_freq_select <= itpg_pkg::IFS_RST;
         o_clk_source <= itpg_pkg::SRC_PRIMARY;
      end else begin
         o_internal_freq_select <= ifs_r;
         o_clk_source <= src;
      end
   end

   // secondary oscillator and power managed availability
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_secondary_keep_running <= 1'b0;
         o_pm_modes_avail <= 1'b0;
      end else begin
         o_secondary_keep_running <= sec_r;
         o_pm_modes_avail <= sec_r | scs_r[1];
      end
   end

   // resulting device clock in kHz
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_sys_freq_khz <= 16'h0000;
      end else begin
         o_sys_freq_khz <= freq_nxt;
      end
   end

endmodule

// File: design/itpg_pkg.sv
package itpg_pkg;
   // timing
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned SLOW_RC_PERIOD_NS = 32000;
   localparam int unsigned SLOW_RC_SETTLE_PERIODS = 8;
   localparam int unsigned SLOW_SETTLE_CYC =
      SLOW_RC_SETTLE_PERIODS * SLOW_RC_PERIOD_NS / CLK_PERIOD_NS;
   localparam int unsigned FAST_SETTLE_MS = 1;
   localparam int unsigned FAST_SETTLE_CYC =
      FAST_SETTLE_MS * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned TRIM_SPAN = 31;
   localparam int unsigned CNT_W = 17;
   // register byte addresses
   localparam logic [3:0] ADR_TUNING = 4'h0;
   localparam logic [3:0] ADR_OSC_CTRL = 4'h4;
   localparam logic [3:0] ADR_STATUS = 4'h8;
   // field positions
   localparam int unsigned TUN_LF_SRC_BIT = 7;
   localparam int unsigned TUN_MUL_EN_BIT = 6;
   localparam int unsigned OSC_IFS_LSB = 4;
   localparam int unsigned OSC_SCS_LSB = 0;
   localparam int unsigned MUL_SHIFT = 2;
   // reset values
   localparam logic [4:0] TRIM_RST = 5'h00;
   localparam logic [2:0] IFS_RST = 3'h4;
   localparam logic [1:0] SCS_RST = 2'h0;
   // codes
   localparam logic [3:0] CFG_INT_A = 4'h9;
   localparam logic [3:0] CFG_INT_B = 4'h8;
   localparam logic [2:0] IFS_8M = 3'h7;
   localparam logic [2:0] IFS_4M = 3'h6;
   localparam logic [15:0] SEC_KHZ = 16'h0020;
   typedef enum logic [1:0] {
      SRC_PRIMARY = 2'b00,
      SRC_SECONDARY = 2'b01,
      SRC_INTERNAL = 2'b11
   } itpg_src_type;
endpackage

// File: design/itpg_trim_if.sv
`timescale 1ns/1ps
// carries one trim target and the code currently applied
interface itpg_trim_if;
   logic signed [4:0] target;
   logic signed [4:0] current;
   modport ctrl (output target, input current);
   modport slew (input target, output current);
endinterface

// File: design/itpg_trim_slew.sv
`timescale 1ns/1ps
// moves the applied trim one step per interval toward the target
module itpg_trim_slew #(
   parameter int unsigned STEP_CYC = 1
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   itpg_trim_if.slew trim
);
   localparam int unsigned CW = itpg_pkg::CNT_W;
   localparam logic [CW-1:0] LAST = CW'(STEP_CYC - 1);
   logic [itpg_pkg::CNT_W-1:0] cnt_r;
   logic signed [4:0] cur_r;
   logic at_target;

   assign at_target = (cur_r == trim.target);
   assign trim.current = cur_r;

   // interval counter runs only while a shift is pending
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         cnt_r <= '0;
      end else if (at_target || cnt_r == LAST) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   // one equal step at the end of each interval
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         cur_r <= itpg_pkg::TRIM_RST;
      end else if (!at_target && cnt_r == LAST) begin
         if (trim.target > cur_r) begin
            cur_r <= cur_r + 5'sd1;
         end else begin
            cur_r <= cur_r - 5'sd1;
         end
      end
   end
endmodule

// File: sim/itpg_chk.sv
`timescale 1ns/1ps
// port-level checker for the oscillator tuning block
module itpg_chk #(
   parameter int unsigned SLOW_SETTLE = 25600,
   parameter int unsigned FAST_SETTLE = 100000
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [3:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   input wire logic [31:0] o_wb_dat,
   input wire logic o_wb_ack,
   input wire logic [3:0] i_primary_osc_config,
   input wire logic [4:0] o_fast_trim_code,
   input wire logic [4:0] o_slow_trim_code,
   input wire logic o_multiplier_on,
   input wire logic o_slow_rc_en,
   input wire logic o_lf_from_fast_osc,
   input wire logic [2:0] o_internal_freq_select,
   input wire logic [1:0] o_clk_source
);
   logic take_w;
   logic [4:0] tgt_r;
   logic [7:0] wd_r;
   int unsigned age_r;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   // a write taken by the slave with the low byte enabled
   assign take_w = i_wb_cyc && i_wb_stb && !o_wb_ack && i_wb_we &&
      i_wb_sel[0];
   // last written byte, for comparing register-driven outputs
   always_ff @(posedge i_clk) begin
      if (take_w) begin
         wd_r <= i_wb_dat[7:0];
      end
   end
   // trim target in offset binary and cycles since it was set
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         tgt_r <= 5'h10;
         age_r <= 0;
      end else if (take_w && i_wb_adr == 4'h0) begin
         tgt_r <= {~i_wb_dat[4], i_wb_dat[3:0]};
         age_r <= 0;
      end else if (age_r < 32'hffff_ffff) begin
         age_r <= age_r + 1;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   chk_ack_after_take: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack
      |=> o_wb_ack) else $error("request not acknowledged");
   chk_ack_one_pulse: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack longer than one cycle");
   chk_bit5_reads_zero: assert property (o_wb_ack && !i_wb_we &&
      i_wb_adr == 4'h0 |-> o_wb_dat[5] == 1'b0 &&
      o_wb_dat[31:8] == 24'h00_0000)
      else $error("tuning read shows unimplemented bits");
   chk_lf_follows_write: assert property (take_w && i_wb_adr == 4'h0
      |-> ##[1:3] o_lf_from_fast_osc == wd_r[7])
      else $error("low frequency source not updated");
   chk_fs_follows_write: assert property (take_w && i_wb_adr == 4'h4
      |-> ##[1:3] o_internal_freq_select == wd_r[6:4])
      else $error("frequency select not updated");
   chk_mult_cfg_gate: assert property (!(i_primary_osc_config inside
      {4'h9, 4'h8}) [*5] |-> !o_multiplier_on)
      else $error("multiplier on outside internal modes");
   chk_mult_fs_gate: assert property (!(o_internal_freq_select inside
      {3'h7, 3'h6}) [*2] |-> !o_multiplier_on)
      else $error("multiplier on at low frequency");
   chk_slow_settle: assert property (age_r > SLOW_SETTLE + 3
      |-> o_slow_trim_code == tgt_r) else $error("slow trim not settled");
   chk_fast_settle: assert property (age_r > FAST_SETTLE + 3
      |-> o_fast_trim_code == tgt_r) else $error("fast trim not settled");
   chk_trim_unit_step: assert property ($changed(o_fast_trim_code)
      |-> 5'(o_fast_trim_code - $past(o_fast_trim_code)) inside {5'h01, 5'h1f})
      else $error("trim moved by more than one step");
   chk_rc_always_on: assert property (o_slow_rc_en)
      else $error("slow rc disabled");
   chk_reset_defaults: assert property ($rose(i_rst_n)
      |-> o_internal_freq_select == 3'h4 && o_clk_source == 2'b00)
      else $error("wrong defaults after reset");
   // main scenarios reached
   cover property (o_multiplier_on);
   cover property (take_w && i_wb_adr == 4'h0);
   cover property (o_lf_from_fast_osc && o_clk_source == 2'b11);
endmodule
bind itpg_top itpg_chk #(.SLOW_SETTLE(SLOW_SETTLE), .FAST_SETTLE(FAST_SETTLE))
   itpg_chk_i (.*);

// File: sim/tb_itpg_top.sv
`timescale 1ns/1ps
// compare an expected value with a seen one and count the outcome
`define check_eq(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
   n_errors++; $display("unexpected %s expected %h seen %h", nm, e, g); \
   end end
module tb_itpg_top;
   logic i_clk = 1'b0, i_rst_n = 1'b0, i_wb_cyc = 1'b0, i_wb_stb = 1'b0;
   logic i_wb_we = 1'b0, i_secondary_osc_en = 1'b0;
   logic [3:0] i_wb_adr = 4'h0, i_wb_sel = 4'h0, i_primary_osc_config = 4'h0;
   logic [31:0] i_wb_dat = 32'h0000_0000, o_wb_dat, scratch;
   logic o_wb_ack, o_multiplier_on, o_fast_osc_en, o_slow_rc_en;
   logic o_lf_from_fast_osc, o_secondary_keep_running, o_pm_modes_avail;
   logic [4:0] o_fast_trim_code, o_slow_trim_code, trim;
   logic [2:0] o_internal_freq_select;
   logic [1:0] o_clk_source;
   logic [15:0] o_sys_freq_khz;
   logic [7:0] lfsr_r = 8'h54;
   logic ok, en;
   int n_errors = 0, total_checks = 0;
   // short settle counts keep the run brief
   itpg_top #(.SLOW_SETTLE(62), .FAST_SETTLE(93)) itpg_top_i (.*);
   // 100 MHz clock
   always #5 i_clk = ~i_clk;
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] lfsr_next(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   // device clock in kHz for a frequency select code
   function automatic logic [15:0] exp_khz(input logic [2:0] fs,
         input logic m);
      logic [15:0] base;
      base = (fs == 3'h0) ? 16'h001f : 16'(16'h007d << (fs - 3'h1));
      return m ? 16'(base << 2) : base;
   endfunction
   // offset binary trim code expected for a signed trim
   function automatic logic [4:0] exp_code(input logic [4:0] t);
      return {~t[4], t[3:0]};
   endfunction
   // one classic wishbone cycle, held until ack is seen
   task automatic wb_cycle(input logic [3:0] adr, input logic we,
         input logic [31:0] wd, input logic [3:0] sel, output logic [31:0] rd);
      int n;
      n = 0;
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_we <= we;
      i_wb_adr <= adr;
      i_wb_sel <= sel;
      i_wb_dat <= wd;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_wb_ack !== 1'b1 && n < 20);
      `check_eq("ack", 1'b1, o_wb_ack)
      rd = o_wb_dat;
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
      i_wb_we <= 1'b0;
      @(posedge i_clk);
   endtask
   task automatic wr(input logic [3:0] adr, input logic [31:0] wd);
      logic [31:0] d;
      wb_cycle(adr, 1'b1, wd, 4'h1, d);
   endtask
   task automatic rd_chk(input logic [3:0] adr, input logic [31:0] e,
         input string nm);
      logic [31:0] d;
      wb_cycle(adr, 1'b0, 32'h0000_0000, 4'hf, d);
      `check_eq(nm, e, d)
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge i_clk);
      n_errors++;
      tally_and_finish;
   end
   // main sequence
   initial begin
      repeat (8) @(posedge i_clk);
      i_rst_n <= 1'b1;
      repeat (2) @(posedge i_clk);
      rd_chk(4'h0, 32'h0000_0000, "tuning");
      rd_chk(4'h4, 32'h0000_0040, "osc_ctrl");
      rd_chk(4'hc, 32'h0000_0000, "unmapped");
      `check_eq("slow_rc_en", 1'b1, o_slow_rc_en)
      `check_eq("fast_trim", 5'h10, o_fast_trim_code)
      // every clock select code
      for (int s = 0; s < 4; s++) begin
         wr(4'h4, 32'h0000_0040 | 32'(s));
         repeat (2) @(posedge i_clk);
         `check_eq("clk_source", {s[1], s[1] | s[0]}, o_clk_source)
      end
      // every primary config, random and edge trims, every frequency
      for (int c = 0; c < 16; c++) begin
         i_primary_osc_config <= 4'(c);
         lfsr_r = lfsr_next(lfsr_r);
         trim = (c == 0) ? 5'h0f : (c == 1) ? 5'h10 : lfsr_r[4:0];
         ok = (c == 9 || c == 8);
         repeat (4) @(posedge i_clk);
         wr(4'h0, {24'h00_0000, lfsr_r[7], 1'b1, lfsr_r[5], trim});
         repeat (100) @(posedge i_clk);
         rd_chk(4'h0, {24'h00_0000, lfsr_r[7], ok, 1'b0, trim},
            "tuning");
         `check_eq("lf_src", lfsr_r[7], o_lf_from_fast_osc)
         `check_eq("slow_trim", exp_code(trim), o_slow_trim_code)
         `check_eq("fast_trim", exp_code(trim), o_fast_trim_code)
         for (int f = 0; f < 8; f++) begin
            wr(4'h4, 32'h0000_0003 | 32'(f << 4));
            repeat (3) @(posedge i_clk);
            en = ok && f >= 6;
            `check_eq("mult_on", en, o_multiplier_on)
            `check_eq("sys_khz", exp_khz(3'(f), en), o_sys_freq_khz)
            `check_eq("fast_en", f != 0 || lfsr_r[7], o_fast_osc_en)
         end
      end
      // leaving the internal modes clears the stored enable
      i_primary_osc_config <= 4'h9;
      repeat (4) @(posedge i_clk);
      wr(4'h0, 32'h0000_0040);
      repeat (100) @(posedge i_clk);
      `check_eq("mult_on", 1'b1, o_multiplier_on)
      rd_chk(4'h8, 32'h0000_019f, "status");
      i_primary_osc_config <= 4'h2;
      repeat (5) @(posedge i_clk);
      `check_eq("mult_on", 1'b0, o_multiplier_on)
      i_primary_osc_config <= 4'h9;
      repeat (5) @(posedge i_clk);
      rd_chk(4'h0, 32'h0000_0000, "tuning");
      // a write without the low byte enable is ignored
      wb_cycle(4'h0, 1'b1, 32'h0000_0085, 4'he, scratch);
      rd_chk(4'h0, 32'h0000_0000, "tuning_sel");
      // secondary oscillator selected
      i_secondary_osc_en <= 1'b1;
      wr(4'h4, 32'h0000_0071);
      repeat (4) @(posedge i_clk);
      `check_eq("sys_khz", itpg_pkg::SEC_KHZ, o_sys_freq_khz)
      `check_eq("sec_run", 1'b1, o_secondary_keep_running)
      `check_eq("pm_avail", 1'b1, o_pm_modes_avail)
      `check_eq("clk_source", 2'b01, o_clk_source)
      // reset in mid-run restores the defaults
      i_rst_n <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
      repeat (2) @(posedge i_clk);
      `check_eq("freq_sel", 3'h4, o_internal_freq_select)
      `check_eq("clk_source", 2'b00, o_clk_source)
      rd_chk(4'h4, 32'h0000_0040, "osc_ctrl");
      tally_and_finish;
   end
endmodule
